// ===== bidir_fifo_cfg.svh
`ifndef BIDIR_FIFO_CFG_SVH
`define BIDIR_FIFO_CFG_SVH

// ----------------------------------------------------------------
// Queue geometry
// ----------------------------------------------------------------
`define Q_WIDTH 36
`define Q_DEPTH 64
`define Q_ADDR_W 6

// ----------------------------------------------------------------
// Preset almost-full / almost-empty offsets, chosen at reset release
// ----------------------------------------------------------------
`define OFFSET_0 7'h10
`define OFFSET_1 7'h0C
`define OFFSET_2 7'h08
`define OFFSET_3 7'h04

// ----------------------------------------------------------------
// Flag reset values, bit order: left full, left almost full,
// left empty, left almost empty, then the same four for the right
// ----------------------------------------------------------------
`define FLAG_RST 8'h22

`endif

// ===== bidir_fifo_pkg.sv
package bidir_fifo_pkg;

	typedef logic [35:0] word_t;

	// Right port bus width, in the order of the two select pins
	typedef enum logic [1:0] {WIDTH_LONG, WIDTH_BYTE, WIDTH_WORD, WIDTH_MAIL} width_t;

	// Byte-order swap modes, in the order of the two select pins
	typedef enum logic [1:0] {SWAP_NONE, SWAP_BYTE, SWAP_WORD, SWAP_BOTH} swap_t;

endpackage : bidir_fifo_pkg

// ===== fifo_queue.sv
`timescale 1ns/1ps
`default_nettype none
`include "bidir_fifo_cfg.svh"

module fifo_queue #(
	parameter int WIDTH = `Q_WIDTH,
	parameter int DEPTH = `Q_DEPTH,
	parameter int AW = `Q_ADDR_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Write side
	input wire logic push_i,
	input wire logic [WIDTH-1:0] push_data_i,
	// Read side
	input wire logic pop_i,
	output logic [WIDTH-1:0] head_o,
	output logic [AW:0] count_o
);

	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;

	always_comb
	begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push_i)
			wr_d = wr_q + {{(AW-1){1'b0}}, 1'b1};
		if (pop_i)
			rd_d = rd_q + {{(AW-1){1'b0}}, 1'b1};
		if (push_i && !pop_i)
			cnt_d = cnt_q + {{AW{1'b0}}, 1'b1};
		else if (pop_i && !push_i)
			cnt_d = cnt_q - {{AW{1'b0}}, 1'b1};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage has no reset; only pointers define contents
	always_ff @(posedge clk_i)
	begin
		if (push_i)
			mem[wr_q] <= push_data_i;
	end

	assign head_o = mem[rd_q];
	assign count_o = cnt_q;

	a_queue_bound: assert property (@(posedge clk_i) disable iff (rst_i)
		(cnt_q == DEPTH_C) |-> !push_i || pop_i)
		else $error("push into a full queue");

	a_count_track: assert property (@(posedge clk_i) disable iff (rst_i)
		(push_i && !pop_i) |=> cnt_q == $past(cnt_q) + 7'h01)
		else $error("queue count did not follow a push");

endmodule : fifo_queue

`default_nettype wire

// ===== bidir_fifo.sv
// Functional notes
// - Two 64 by 36 queues, left to right and right to left.
// - Transfers happen only at a port clock rising edge, when enabled.
// - Port clocks independent; simultaneous read and write both accepted.
// - Full and almost-full pass two stages on the writing port clock.
// - Empty and almost-empty pass two stages on the reading port clock.
// - Right port moves long words, words or bytes, either endianness.
// - Endian low uses upper bus lanes, high uses lower lanes.
// - Right port offers three swap modes plus straight, at every width.
// - Width and endian selection registered on the right port clock.
// - Two 36-bit mailboxes bypass the queues, each with a mail flag.
// - Parity checked passively, reported only, never blocks a transfer.
// - Each port may generate parity on data it outputs.
// - Almost-empty low when read queue count is at most the offset.
// - Almost-full low when free write-queue space is at most the offset.
// - Access only while select is low and enable is high.
// - Data bus drivers released while the port select is high.
// - Empty flag low inhibits reads except later pieces of a narrow read; high lets a read load output.
// - Empty flag reset low, rises second read-clock edge after a write.
// - Full flag low means full; further writes are ignored.
// - Full flag reset low, rises second own-clock edge after reset.
// - Reset sets almost-full, mail and parity-error flags high, others low.
// - Offset selects captured at reset release choose one of four offsets.
// - Mailbox write drops its flag and blocks writes until opposite read.
`timescale 1ns/1ps
`default_nettype none
`include "bidir_fifo_cfg.svh"

module bidir_fifo #(
	parameter int DEPTH = `Q_DEPTH,
	parameter int AW = `Q_ADDR_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Shared options
	input wire logic odd_parity_i,
	input wire logic offset_select_lo_i,
	input wire logic offset_select_hi_i,
	// Left port inputs
	input wire logic left_port_clock_i,
	input wire logic left_port_select_n_i,
	input wire logic left_port_enable_i,
	input wire logic left_write_not_read_i,
	input wire logic left_mail_select_i,
	input wire logic left_parity_gen_i,
	input wire logic [35:0] left_data_bus_i,
	// Left port outputs
	output logic [35:0] left_data_bus_o,
	output logic left_data_bus_oe_o,
	output logic left_empty_n_o,
	output logic left_full_n_o,
	output logic left_almost_empty_n_o,
	output logic left_almost_full_n_o,
	output logic left_parity_error_n_o,
	output logic mail_in_left_flag_n_o,
	// Right port inputs
	input wire logic right_port_clock_i,
	input wire logic right_port_select_n_i,
	input wire logic right_port_enable_i,
	input wire logic right_write_not_read_i,
	input wire logic right_width_sel_lo_i,
	input wire logic right_width_sel_hi_i,
	input wire logic endian_select_i,
	input wire logic swap_mode_lo_i,
	input wire logic swap_mode_hi_i,
	input wire logic right_parity_gen_i,
	input wire logic [35:0] right_data_bus_i,
	// Right port outputs
	output logic [35:0] right_data_bus_o,
	output logic right_data_bus_oe_o,
	output logic right_empty_n_o,
	output logic right_full_n_o,
	output logic right_almost_empty_n_o,
	output logic right_almost_full_n_o,
	output logic right_parity_error_n_o,
	output logic mail_in_right_flag_n_o
);

	localparam int CW = AW + 1;
	localparam int SYNC_W = 91;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [CW-1:0] ONE_C = CW'(1);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] par_fail(input bidir_fifo_pkg::word_t w, input logic odd);
		for (int i = 0; i < 4; i++)
			par_fail[i] = (^w[9*i +: 9]) != odd;
	endfunction : par_fail

	function automatic bidir_fifo_pkg::word_t gen_par(input bidir_fifo_pkg::word_t w,
		input logic odd);
		gen_par = w;
		for (int i = 0; i < 4; i++)
			gen_par[9*i+8] = (^w[9*i +: 8]) ^ odd;
	endfunction : gen_par

	function automatic bidir_fifo_pkg::word_t byte_swap(input bidir_fifo_pkg::word_t w,
		input bidir_fifo_pkg::swap_t m);
		case (m)
			bidir_fifo_pkg::SWAP_BYTE: byte_swap = {w[8:0], w[17:9], w[26:18], w[35:27]};
			bidir_fifo_pkg::SWAP_WORD: byte_swap = {w[17:0], w[35:18]};
			bidir_fifo_pkg::SWAP_BOTH: byte_swap = {w[26:18], w[35:27], w[8:0], w[17:9]};
			default: byte_swap = w;
		endcase
	endfunction : byte_swap

	// ----------------------------------------------------------------
	// Pin synchronisers and port clock edge detect
	// ----------------------------------------------------------------
	// Whole pin set shares one delay so data stays aligned to its clock
	logic [SYNC_W-1:0] pin_raw, sync1_q, sync2_q;
	logic odd_s, fs_hi_s, fs_lo_s;
	logic clk_a_s, cs_a_s, en_a_s, wnr_a_s, msel_a_s, pgen_a_s;
	logic clk_b_s, cs_b_s, en_b_s, wnr_b_s, wsel_hi_s, wsel_lo_s;
	logic endian_s, sw_hi_s, sw_lo_s, pgen_b_s;
	logic [35:0] data_a_s, data_b_s;
	logic clk_a_prev_q, clk_b_prev_q, edge_a, edge_b;

	assign pin_raw = {odd_parity_i, offset_select_hi_i, offset_select_lo_i,
		left_port_clock_i, left_port_select_n_i, left_port_enable_i,
		left_write_not_read_i, left_mail_select_i, left_parity_gen_i, left_data_bus_i,
		right_port_clock_i, right_port_select_n_i, right_port_enable_i,
		right_write_not_read_i, right_width_sel_hi_i, right_width_sel_lo_i,
		endian_select_i, swap_mode_hi_i, swap_mode_lo_i, right_parity_gen_i,
		right_data_bus_i};

	always_ff @(posedge clk_i)
	begin
		sync1_q <= pin_raw;
		sync2_q <= sync1_q;
		clk_a_prev_q <= clk_a_s;
		clk_b_prev_q <= clk_b_s;
	end

	assign {odd_s, fs_hi_s, fs_lo_s, clk_a_s, cs_a_s, en_a_s, wnr_a_s, msel_a_s, pgen_a_s,
		data_a_s, clk_b_s, cs_b_s, en_b_s, wnr_b_s, wsel_hi_s, wsel_lo_s, endian_s,
		sw_hi_s, sw_lo_s, pgen_b_s, data_b_s} = sync2_q;

	assign edge_a = clk_a_s & ~clk_a_prev_q & ~rst_i;
	assign edge_b = clk_b_s & ~clk_b_prev_q & ~rst_i;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	bidir_fifo_pkg::word_t mail_lr_q, mail_lr_d, mail_rl_q, mail_rl_d;
	bidir_fifo_pkg::word_t ldout_q, ldout_d, rdout_q, rdout_d;
	bidir_fifo_pkg::word_t asm_q, asm_d, hold_q, hold_d, rword, rpiece;
	bidir_fifo_pkg::width_t width_q, width_d;
	bidir_fifo_pkg::swap_t swap_q, swap_d, swap_s, swap_eff;
	logic mbf_l_q, mbf_l_d, mbf_r_q, mbf_r_d;
	logic loe_q, loe_d, roe_q, roe_d, lperr_q, lperr_d, rperr_q, rperr_d;
	logic endian_q, endian_d, rst_prev_q, rst_prev_d;
	logic [1:0] piece_q, piece_d, last_idx, slot;
	logic [3:0] rmask;
	logic [CW-1:0] off_q, off_d;
	logic [7:0] flag_q, flag_raw, flag_edge;

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	logic acc_a, acc_b, is_mail, last_piece;
	logic mail_lr_wr, mail_lr_rd, mail_rl_wr, mail_rl_rd;
	logic push_lr, pop_lr, push_rl, pop_rl, wr_b, rd_b;
	bidir_fifo_pkg::word_t head_lr, head_rl;
	logic [CW-1:0] cnt_lr, cnt_rl, cnt_lr_after, cnt_rl_after;

	assign acc_a = edge_a & ~cs_a_s & en_a_s;
	assign acc_b = edge_b & ~cs_b_s & en_b_s;
	assign mail_lr_wr = acc_a & wnr_a_s & msel_a_s & mbf_l_q;
	assign mail_rl_rd = acc_a & ~wnr_a_s & msel_a_s;
	assign push_lr = acc_a & wnr_a_s & ~msel_a_s & flag_q[0];
	assign pop_rl = acc_a & ~wnr_a_s & ~msel_a_s & flag_q[2];

	assign is_mail = width_q == bidir_fifo_pkg::WIDTH_MAIL;
	assign mail_rl_wr = acc_b & wnr_b_s & is_mail & mbf_r_q;
	assign mail_lr_rd = acc_b & ~wnr_b_s & is_mail;
	assign wr_b = acc_b & wnr_b_s & ~is_mail & flag_q[4];
	// Later pieces of a narrow read come from the held word
	assign rd_b = acc_b & ~wnr_b_s & ~is_mail & ((piece_q != 2'h0) | flag_q[6]);

	always_comb
	begin
		case (width_q)
			bidir_fifo_pkg::WIDTH_BYTE: last_idx = 2'h3;
			bidir_fifo_pkg::WIDTH_WORD: last_idx = 2'h1;
			default: last_idx = 2'h0;
		endcase
	end

	assign last_piece = piece_q == last_idx;
	assign slot = endian_q ? piece_q : last_idx - piece_q;
	assign swap_s = bidir_fifo_pkg::swap_t'({sw_hi_s, sw_lo_s});
	assign swap_eff = (piece_q == 2'h0) ? swap_s : swap_q;
	assign pop_lr = rd_b & (piece_q == 2'h0);
	assign push_rl = wr_b & last_piece;

	// ----------------------------------------------------------------
	// Queues
	// ----------------------------------------------------------------
	fifo_queue #(.WIDTH(36), .DEPTH(DEPTH), .AW(AW)) u_left_to_right_queue (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push_i(push_lr),
		.push_data_i(data_a_s),
		.pop_i(pop_lr),
		.head_o(head_lr),
		.count_o(cnt_lr)
	);

	fifo_queue #(.WIDTH(36), .DEPTH(DEPTH), .AW(AW)) u_right_to_left_queue (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push_i(push_rl),
		.push_data_i(byte_swap(asm_d, swap_eff)),
		.pop_i(pop_rl),
		.head_o(head_rl),
		.count_o(cnt_rl)
	);

	// ----------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------
	// Counts after this cycle, so a port's own access drops its flag at once
	assign cnt_lr_after = cnt_lr + (push_lr ? ONE_C : '0) - (pop_lr ? ONE_C : '0);
	assign cnt_rl_after = cnt_rl + (push_rl ? ONE_C : '0) - (pop_rl ? ONE_C : '0);

	assign flag_raw[0] = cnt_lr_after != DEPTH_C;
	assign flag_raw[1] = (DEPTH_C - cnt_lr_after) > off_q;
	assign flag_raw[2] = cnt_rl_after != '0;
	assign flag_raw[3] = cnt_rl_after > off_q;
	assign flag_raw[4] = cnt_rl_after != DEPTH_C;
	assign flag_raw[5] = (DEPTH_C - cnt_rl_after) > off_q;
	assign flag_raw[6] = cnt_lr_after != '0;
	assign flag_raw[7] = cnt_lr_after > off_q;
	assign flag_edge = {{4{edge_b}}, {4{edge_a}}};

	for (genvar i = 0; i < 8; i++)
	begin : g_flag
		logic s1_q, s1_d, s2_q, s2_d;
		always_comb
		begin
			s1_d = s1_q;
			s2_d = s2_q;
			if (flag_edge[i])
			begin
				s1_d = flag_raw[i];
				s2_d = s1_q & flag_raw[i];
			end
		end
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				s1_q <= 1'(`FLAG_RST >> i);
				s2_q <= 1'(`FLAG_RST >> i);
			end
			else
			begin
				s1_q <= s1_d;
				s2_q <= s2_d;
			end
		end
		assign flag_q[i] = s2_q;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		mail_lr_d = mail_lr_q;
		mail_rl_d = mail_rl_q;
		mbf_l_d = mbf_l_q;
		mbf_r_d = mbf_r_q;
		ldout_d = ldout_q;
		rdout_d = rdout_q;
		asm_d = asm_q;
		hold_d = hold_q;
		piece_d = piece_q;
		swap_d = swap_q;
		width_d = width_q;
		endian_d = endian_q;
		off_d = off_q;
		rst_prev_d = rst_i;
		loe_d = ~cs_a_s & ~wnr_a_s;
		roe_d = ~cs_b_s & ~wnr_b_s;
		if (edge_b)
		begin
			width_d = bidir_fifo_pkg::width_t'({wsel_hi_s, wsel_lo_s});
			endian_d = endian_s;
		end
		if (wr_b)
		begin
			case (width_q)
				bidir_fifo_pkg::WIDTH_BYTE:
					asm_d[9*slot +: 9] = endian_q ? data_b_s[8:0] : data_b_s[35:27];
				bidir_fifo_pkg::WIDTH_WORD:
					asm_d[18*slot[0] +: 18] = endian_q ? data_b_s[17:0] : data_b_s[35:18];
				default:
					asm_d = data_b_s;
			endcase
		end
		rword = (piece_q == 2'h0) ? byte_swap(head_lr, swap_s) : hold_q;
		case (width_q)
			bidir_fifo_pkg::WIDTH_BYTE:
				rpiece = endian_q ? {27'h0, rword[9*slot +: 9]} : {rword[9*slot +: 9], 27'h0};
			bidir_fifo_pkg::WIDTH_WORD:
				rpiece = endian_q ? {18'h0, rword[18*slot[0] +: 18]}
					: {rword[18*slot[0] +: 18], 18'h0};
			default:
				rpiece = rword;
		endcase
		if (rd_b)
		begin
			hold_d = rword;
			rdout_d = right_parity_gen_sel(rpiece);
		end
		if (wr_b || rd_b)
		begin
			piece_d = last_piece ? 2'h0 : piece_q + 2'h1;
			if (piece_q == 2'h0)
				swap_d = swap_s;
		end
		if (pop_rl)
			ldout_d = pgen_a_s ? gen_par(head_rl, odd_s) : head_rl;
		// Opposite read frees the box before a new write may refill it
		if (mail_rl_rd)
		begin
			ldout_d = pgen_a_s ? gen_par(mail_rl_q, odd_s) : mail_rl_q;
			mbf_r_d = 1'b1;
		end
		if (mail_lr_rd)
		begin
			rdout_d = right_parity_gen_sel(mail_lr_q);
			mbf_l_d = 1'b1;
		end
		if (mail_lr_wr)
		begin
			mail_lr_d = data_a_s;
			mbf_l_d = 1'b0;
		end
		if (mail_rl_wr)
		begin
			mail_rl_d = data_b_s;
			mbf_r_d = 1'b0;
		end
		case (width_q)
			bidir_fifo_pkg::WIDTH_BYTE: rmask = endian_q ? 4'h1 : 4'h8;
			bidir_fifo_pkg::WIDTH_WORD: rmask = endian_q ? 4'h3 : 4'hC;
			default: rmask = 4'hF;
		endcase
		// Parity trees are shared with mailbox generation, hence the forced pass
		lperr_d = ~(|par_fail(data_a_s, odd_s)) | (~wnr_a_s & msel_a_s & pgen_a_s);
		rperr_d = ~(|(par_fail(data_b_s, odd_s) & rmask)) | (~wnr_b_s & is_mail & pgen_b_s);
		if (rst_prev_q && !rst_i)
		begin
			case ({fs_hi_s, fs_lo_s})
				2'h0: off_d = CW'(`OFFSET_0);
				2'h1: off_d = CW'(`OFFSET_1);
				2'h2: off_d = CW'(`OFFSET_2);
				default: off_d = CW'(`OFFSET_3);
			endcase
		end
	end

	function automatic bidir_fifo_pkg::word_t right_parity_gen_sel(input bidir_fifo_pkg::word_t w);
		right_parity_gen_sel = pgen_b_s ? gen_par(w, odd_s) : w;
	endfunction : right_parity_gen_sel

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mail_lr_q <= '0;
			mail_rl_q <= '0;
			mbf_l_q <= 1'b1;
			mbf_r_q <= 1'b1;
			ldout_q <= '0;
			rdout_q <= '0;
			asm_q <= '0;
			hold_q <= '0;
			piece_q <= 2'h0;
			swap_q <= bidir_fifo_pkg::SWAP_NONE;
			width_q <= bidir_fifo_pkg::WIDTH_LONG;
			endian_q <= 1'b0;
			off_q <= CW'(`OFFSET_0);
			rst_prev_q <= 1'b1;
			loe_q <= 1'b0;
			roe_q <= 1'b0;
			lperr_q <= 1'b1;
			rperr_q <= 1'b1;
		end
		else
		begin
			mail_lr_q <= mail_lr_d;
			mail_rl_q <= mail_rl_d;
			mbf_l_q <= mbf_l_d;
			mbf_r_q <= mbf_r_d;
			ldout_q <= ldout_d;
			rdout_q <= rdout_d;
			asm_q <= asm_d;
			hold_q <= hold_d;
			piece_q <= piece_d;
			swap_q <= swap_d;
			width_q <= width_d;
			endian_q <= endian_d;
			off_q <= off_d;
			rst_prev_q <= rst_prev_d;
			loe_q <= loe_d;
			roe_q <= roe_d;
			lperr_q <= lperr_d;
			rperr_q <= rperr_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign left_data_bus_o = ldout_q;
	assign left_data_bus_oe_o = loe_q;
	assign left_full_n_o = flag_q[0];
	assign left_almost_full_n_o = flag_q[1];
	assign left_empty_n_o = flag_q[2];
	assign left_almost_empty_n_o = flag_q[3];
	assign left_parity_error_n_o = lperr_q;
	assign mail_in_left_flag_n_o = mbf_l_q;
	assign right_data_bus_o = rdout_q;
	assign right_data_bus_oe_o = roe_q;
	assign right_full_n_o = flag_q[4];
	assign right_almost_full_n_o = flag_q[5];
	assign right_empty_n_o = flag_q[6];
	assign right_almost_empty_n_o = flag_q[7];
	assign right_parity_error_n_o = rperr_q;
	assign mail_in_right_flag_n_o = mbf_r_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_reset_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> !left_empty_n_o && !right_full_n_o && left_almost_full_n_o
			&& !right_almost_empty_n_o && mail_in_right_flag_n_o)
		else $error("flags wrong after reset");
	a_full_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		(cnt_lr == DEPTH_C) |-> !left_full_n_o)
		else $error("write taken while full");
	a_empty_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		(cnt_rl != '0 || !left_empty_n_o) && (cnt_lr != '0 || !right_empty_n_o))
		else $error("read taken while empty");
	a_access_qual: assert property (@(posedge clk_i) disable iff (rst_i)
		(push_lr || pop_rl || mail_lr_wr) |-> edge_a && !cs_a_s && en_a_s)
		else $error("left access without qualifying edge");
	a_full_sync: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(left_full_n_o) || $rose(right_almost_full_n_o)
			|-> ($rose(left_full_n_o) ? $past(edge_a) : $past(edge_b)))
		else $error("full flag moved off its port edge");
	a_empty_sync: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(right_empty_n_o) |-> $past(edge_b))
		else $error("empty flag moved off reading edge");
	a_mail_block: assert property (@(posedge clk_i) disable iff (rst_i)
		mail_lr_wr |=> !mail_in_left_flag_n_o && mail_lr_q == $past(data_a_s))
		else $error("mailbox write not stored or flagged");
	a_oe_off: assert property (@(posedge clk_i) disable iff (rst_i)
		cs_a_s |=> !left_data_bus_oe_o)
		else $error("left driver on while deselected");
	a_parity_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		(acc_a && wnr_a_s && !msel_a_s && left_full_n_o) |-> push_lr)
		else $error("write blocked by parity");

endmodule : bidir_fifo

`default_nettype wire

// ===== port_host.sv
`timescale 1ns/1ps
`default_nettype none

module port_host #(
	parameter real HALF = 48.0
) (
	// Device side of the bus
	input wire logic [35:0] dev_data_i,
	input wire logic dev_oe_i,
	// Host pins
	output logic clk_o,
	output logic sel_n_o,
	output logic en_o,
	output logic wnr_o,
	output logic mail_o,
	output logic [35:0] data_o
);
	logic [35:0] drv_q;
	logic drive_q;

	initial
	begin
		clk_o = 1'b0;
		sel_n_o = 1'b1;
		en_o = 1'b0;
		wnr_o = 1'b0;
		mail_o = 1'b0;
		drv_q = 36'h0_0000_0000;
		drive_q = 1'b0;
	end

	// Free-running, as the port clock is
	always #(HALF) clk_o = ~clk_o;

	// Undriven bus shows the inverse, so a missing driver cannot pass
	assign data_o = dev_oe_i ? dev_data_i : (drive_q ? drv_q : ~drv_q);

	// Pins move at the falling edge, stable around the rising one
	task automatic access(input logic wr, input logic mb, input logic [35:0] wd,
		output logic [35:0] rd);
		@(negedge clk_o);
		sel_n_o = 1'b0;
		en_o = 1'b1;
		wnr_o = wr;
		mail_o = mb;
		drv_q = wd;
		drive_q = wr;
		@(posedge clk_o);
		@(negedge clk_o);
		rd = data_o;
		en_o = 1'b0;
		sel_n_o = 1'b1;
		drive_q = 1'b0;
	endtask : access
endmodule : port_host

`default_nettype wire

// ===== bidir_fifo_tb.sv
`timescale 1ns/1ps
`default_nettype none

module bidir_fifo_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic odd_parity_i = 1'b0;
	logic offset_select_lo_i = 1'b0;
	logic offset_select_hi_i = 1'b0;
	logic left_parity_gen_i = 1'b0;
	logic right_parity_gen_i = 1'b0;
	logic endian_select_i = 1'b0;
	logic [1:0] wsel = 2'h0;
	logic [1:0] swp = 2'h0;
	logic left_port_clock_i, left_port_select_n_i, left_port_enable_i, left_write_not_read_i;
	logic left_mail_select_i, left_data_bus_oe_o, left_empty_n_o, left_full_n_o;
	logic left_almost_empty_n_o, left_almost_full_n_o, left_parity_error_n_o;
	logic right_port_clock_i, right_port_select_n_i, right_port_enable_i, right_write_not_read_i;
	logic right_data_bus_oe_o, right_empty_n_o, right_full_n_o, right_almost_empty_n_o;
	logic right_almost_full_n_o, right_parity_error_n_o, mb_unused;
	logic mail_in_left_flag_n_o, mail_in_right_flag_n_o;
	logic [35:0] left_data_bus_i, left_data_bus_o, right_data_bus_i, right_data_bus_o, rd;
	logic [7:0] flags;
	int n_fail = 0;
	int comparisons = 0;

	always #4 clk_i = ~clk_i;

	assign flags = {left_full_n_o, left_almost_full_n_o, left_empty_n_o, left_almost_empty_n_o,
		right_full_n_o, right_almost_full_n_o, right_empty_n_o, right_almost_empty_n_o};

	bidir_fifo i_dut (
		.clk_i, .rst_i, .odd_parity_i, .offset_select_lo_i, .offset_select_hi_i,
		.left_port_clock_i, .left_port_select_n_i, .left_port_enable_i, .left_write_not_read_i,
		.left_mail_select_i, .left_parity_gen_i, .left_data_bus_i, .left_data_bus_o,
		.left_data_bus_oe_o, .left_empty_n_o, .left_full_n_o, .left_almost_empty_n_o,
		.left_almost_full_n_o, .left_parity_error_n_o, .mail_in_left_flag_n_o,
		.right_port_clock_i, .right_port_select_n_i, .right_port_enable_i,
		.right_write_not_read_i, .right_width_sel_lo_i(wsel[0]), .right_width_sel_hi_i(wsel[1]),
		.endian_select_i, .swap_mode_lo_i(swp[0]), .swap_mode_hi_i(swp[1]), .right_parity_gen_i,
		.right_data_bus_i, .right_data_bus_o, .right_data_bus_oe_o, .right_empty_n_o,
		.right_full_n_o, .right_almost_empty_n_o, .right_almost_full_n_o,
		.right_parity_error_n_o, .mail_in_right_flag_n_o
	);

	port_host #(.HALF(48.0)) hl (.dev_data_i(left_data_bus_o), .dev_oe_i(left_data_bus_oe_o),
		.clk_o(left_port_clock_i), .sel_n_o(left_port_select_n_i), .en_o(left_port_enable_i),
		.wnr_o(left_write_not_read_i), .mail_o(left_mail_select_i), .data_o(left_data_bus_i));
	port_host #(.HALF(56.0)) hr (.dev_data_i(right_data_bus_o), .dev_oe_i(right_data_bus_oe_o),
		.clk_o(right_port_clock_i), .sel_n_o(right_port_select_n_i), .en_o(right_port_enable_i),
		.wnr_o(right_write_not_read_i), .mail_o(mb_unused), .data_o(right_data_bus_i));

	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	// Width and endian take effect one right edge after they are sampled; swap on the edge that samples it
	task automatic rcfg(input logic [1:0] w, input logic [1:0] s, input logic e);
		wsel = w;
		swp = s;
		endian_select_i = e;
		repeat (2) @(negedge right_port_clock_i);
	endtask : rcfg

	function automatic logic [35:0] swapped(input logic [35:0] w, input logic [1:0] m);
		case (m)
			2'h1: return {w[8:0], w[17:9], w[26:18], w[35:27]};
			2'h2: return {w[17:0], w[35:18]};
			2'h3: return {w[26:18], w[35:27], w[8:0], w[17:9]};
			default: return w;
		endcase
	endfunction : swapped

	function automatic logic [35:0] pat(input int i);
		return {4'h5, 8'(i), 8'(~i), 8'(i + 3), 8'(i * 5)};
	endfunction : pat

	initial
	begin
		// Held long enough for four edges of each port clock
		repeat (60) @(posedge clk_i);
		#1;
		chk("reset flags", 8'h44, flags);
		chk("reset mail flags", 2'h3, {mail_in_left_flag_n_o, mail_in_right_flag_n_o});
		rst_i = 1'b0;
		for (int i = 0; i < 400 && !(left_full_n_o === 1'b1 && right_full_n_o === 1'b1); i++)
			@(posedge clk_i) #1;
		chk("full after reset", 2'h3, {left_full_n_o, right_full_n_o});
		chk("idle flags", 8'hCC, flags);
		hl.access(1'b1, 1'b0, pat(99), rd);
		chk("empty before sync", 1'b0, right_empty_n_o);
		repeat (3) @(negedge right_port_clock_i);
		chk("empty after sync", 1'b1, right_empty_n_o);
		hr.access(1'b0, 1'b0, 36'h0_0000_0000, rd);
		chk("first word", pat(99), rd);
		hr.access(1'b0, 1'b0, 36'h0_0000_0000, rd);
		chk("read when empty", pat(99), rd);
		for (int i = 0; i < 65; i++)
		begin
			hl.access(1'b1, 1'b0, pat(i), rd);
			@(negedge left_port_clock_i);
			chk("almost full", 1'(63 - i > 16), left_almost_full_n_o);
			chk("full", 1'(i < 63), left_full_n_o);
		end
		for (int i = 0; i < 64; i++)
		begin
			hr.access(1'b0, 1'b0, 36'h0_0000_0000, rd);
			@(negedge right_port_clock_i);
			chk("queue order", pat(i), rd);
			chk("almost empty", 1'(63 - i > 16), right_almost_empty_n_o);
		end
		hr.access(1'b0, 1'b0, 36'h0_0000_0000, rd);
		chk("write past full", pat(63), rd);
		for (int m = 0; m < 4; m++)
		begin
			rcfg(2'h0, 2'(m), 1'b0);
			hr.access(1'b1, 1'b0, 36'h1_2345_6789, rd);
			repeat (3) @(negedge left_port_clock_i);
			hl.access(1'b0, 1'b0, 36'h0_0000_0000, rd);
			chk("swap", swapped(36'h1_2345_6789, 2'(m)), rd);
		end
		rcfg(2'h1, 2'h0, 1'b0);
		for (int p = 0; p < 4; p++)
			hr.access(1'b1, 1'b0, {9'(p + 9'h1a0), 27'h0}, rd);
		rcfg(2'h2, 2'h0, 1'b1);
		hr.access(1'b1, 1'b0, {18'h0, 18'h1_2345}, rd);
		hr.access(1'b1, 1'b0, {18'h0, 18'h2_abcd}, rd);
		repeat (3) @(negedge left_port_clock_i);
		hl.access(1'b0, 1'b0, 36'h0_0000_0000, rd);
		chk("byte lanes", {9'h1a0, 9'h1a1, 9'h1a2, 9'h1a3}, rd);
		hl.access(1'b0, 1'b0, 36'h0_0000_0000, rd);
		chk("word lanes", {18'h2_abcd, 18'h1_2345}, rd);
		rcfg(2'h0, 2'h0, 1'b0);
		hr.access(1'b1, 1'b0, 36'h0_0000_0001, rd);
		chk("parity error", 1'b0, right_parity_error_n_o);
		hr.access(1'b1, 1'b0, 36'h0_0000_0001, rd);
		repeat (3) @(negedge left_port_clock_i);
		hl.access(1'b0, 1'b0, 36'h0_0000_0000, rd);
		chk("raw data", 36'h0_0000_0001, rd);
		left_parity_gen_i = 1'b1;
		hl.access(1'b0, 1'b0, 36'h0_0000_0000, rd);
		chk("generated parity", 36'h0_0000_0101, rd);
		left_parity_gen_i = 1'b0;
		hl.access(1'b1, 1'b1, 36'h0_cafe_0001, rd);
		chk("left parity error", 1'b0, left_parity_error_n_o);
		chk("mail flag set", 1'b0, mail_in_left_flag_n_o);
		hl.access(1'b1, 1'b1, 36'h0_0bad_0002, rd);
		rcfg(2'h3, 2'h0, 1'b0);
		hr.access(1'b0, 1'b0, 36'h0_0000_0000, rd);
		chk("mail data", 36'h0_cafe_0001, rd);
		hr.access(1'b1, 1'b0, 36'h0_5a5a_0003, rd);
		chk("right mail flag set", 1'b0, mail_in_right_flag_n_o);
		hl.access(1'b0, 1'b1, 36'h0_0000_0000, rd);
		chk("right mail data", 36'h0_5a5a_0003, rd);
		chk("right mail flag clear", 1'b1, mail_in_right_flag_n_o);
		repeat (3) @(negedge left_port_clock_i);
		chk("mail flag clear", 1'b1, mail_in_left_flag_n_o);
		chk("bus released", 2'h0, {left_data_bus_oe_o, right_data_bus_oe_o});
		finish_test();
	end
endmodule : bidir_fifo_tb

`default_nettype wire
